// file: rtl/erssa_alu.sv
// Behaviour
// (RULE_01) rotate left moves bits up, bit 7 into bit 0, flags kept.
// (RULE_02) to-work variants write the work register and leave memory alone.
// (RULE_03) rotate left through carry: carry into bit 0, bit 7 into carry.
// (RULE_04) rotate right moves bits down, bit 0 into bit 7, flags kept.
// (RULE_05) rotate right through carry: carry into bit 7, bit 0 into carry.
// (RULE_06) subtract with borrow: work minus operand minus inverted carry.
// (RULE_07) memory form of subtract with borrow writes the memory byte.
// (RULE_08) plain subtract: work minus operand, to work or memory.
// (RULE_09) after subtract carry clear if negative, set if zero or positive.
// (RULE_10) subtract updates signed range, zero, half carry, carry, SC, CZ.
// (RULE_11) a met skip adds one dummy cycle, making three cycles in all.
// (RULE_12) decrement skip writes byte minus one, skips if it is zero.
// (RULE_13) decrement to work loads byte minus one, skips if work is zero.
// (RULE_14) increment skip writes byte plus one, skips if it wrapped to zero.
// (RULE_15) increment to work loads byte plus one, skips if work is zero.
// (RULE_16) set all ones writes FFh into the byte, flags kept.
// (RULE_17) set bit forces only the chosen bit to one, flags kept.
// (RULE_18) bit skip skips when the chosen bit is one.
// (RULE_19) nonzero skip rewrites the byte unchanged, skips when nonzero.
// (RULE_20) nibble exchange swaps the halves into memory or work, flags kept.
// (RULE_21) any section reachable; read, modify, write inside the op cycles.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module erssa_alu (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic op_busy,
    output logic skip_cycle,
    output logic op_done
);
    typedef struct packed {
        erssa_pkg::erssa_state_t state;
        erssa_pkg::erssa_op_t op;
        logic [erssa_pkg::CMD_BIT_W-1:0] bit_sel;
        logic [erssa_pkg::MEM_AW-1:0] addr;
        logic [7:0] operand;
        logic [7:0] work;
        logic [erssa_pkg::FLAGS_W-1:0] flags;
        logic skip_last;
        logic done;
        logic [erssa_pkg::MEM_AW-1:0] maddr;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic [erssa_pkg::MEM_DEPTH-1:0][7:0] mem;
    } erssa_regs_t;

    erssa_regs_t r_reg;
    erssa_regs_t r_next;
    logic [31:0] rd;
    logic [7:0] res;
    logic [8:0] diff;
    logic [8:0] nib;
    logic borrow_in;
    logic skip;
    logic wr_mem;
    logic wr_work;
    logic carry_now;

    // a - b - bin over nine bits; bit 8 is the borrow out
    function automatic logic [8:0] sub9(input logic [8:0] a, input logic [8:0] b,
                                        input logic bin);
        sub9 = a - b - {8'h00, bin};
    endfunction

    assign carry_now = r_reg.flags[erssa_pkg::FLG_C];
    assign hrdata = r_reg.hrdata;
    // zero wait states: every access completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = erssa_pkg::HRESP_OKAY;
    assign op_busy = (r_reg.state != erssa_pkg::ST_IDLE);
    assign skip_cycle = (r_reg.state == erssa_pkg::ST_DUMMY);
    assign op_done = r_reg.done;

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        rd = 32'h00000000;
        res = r_reg.operand;
        skip = 1'b0;
        wr_mem = 1'b0;
        wr_work = 1'b0;
        borrow_in = 1'b0;
        diff = 9'h000;
        nib = 9'h000;

        // read data is captured in the address phase, so data is a flop
        if (haddr[7:0] == erssa_pkg::OFS_CMD) begin
            rd[erssa_pkg::CMD_OP_LSB +: erssa_pkg::CMD_OP_W] = r_reg.op;
            rd[erssa_pkg::CMD_BIT_LSB +: erssa_pkg::CMD_BIT_W] = r_reg.bit_sel;
            rd[erssa_pkg::CMD_ADDR_LSB +: erssa_pkg::MEM_AW] = r_reg.addr;
        end else if (haddr[7:0] == erssa_pkg::OFS_WORK) begin
            rd[7:0] = r_reg.work;
        end else if (haddr[7:0] == erssa_pkg::OFS_FLAGS) begin
            rd[erssa_pkg::FLAGS_W-1:0] = r_reg.flags;
        end else if (haddr[7:0] == erssa_pkg::OFS_STAT) begin
            rd[erssa_pkg::STAT_BUSY] = op_busy;
            rd[erssa_pkg::STAT_SKIP] = r_reg.skip_last;
        end else if (haddr[7:0] == erssa_pkg::OFS_MADDR) begin
            rd[erssa_pkg::MEM_AW-1:0] = r_reg.maddr;
        end else if (haddr[7:0] == erssa_pkg::OFS_MDATA) begin
            rd[7:0] = r_reg.mem[r_reg.maddr];
        end

        r_next.ap_valid = hsel && hready && (htrans == erssa_pkg::HTRANS_NONSEQ)
                          && (hsize == erssa_pkg::HSIZE_WORD);
        r_next.ap_write = hwrite;
        r_next.ap_addr = haddr[7:0];
        if (r_next.ap_valid && !hwrite) begin
            r_next.hrdata = rd;
        end

        // bus writes first; the sequencer below overrides in the same cycle
        if (r_reg.ap_valid && r_reg.ap_write) begin
            if (r_reg.ap_addr == erssa_pkg::OFS_CMD) begin
                // a command while busy is dropped
                if (r_reg.state == erssa_pkg::ST_IDLE) begin
                    r_next.op = erssa_pkg::erssa_op_t'(
                        hwdata[erssa_pkg::CMD_OP_LSB +: erssa_pkg::CMD_OP_W]);
                    r_next.bit_sel = hwdata[erssa_pkg::CMD_BIT_LSB +: erssa_pkg::CMD_BIT_W];
                    r_next.addr = hwdata[erssa_pkg::CMD_ADDR_LSB +: erssa_pkg::MEM_AW];
                    r_next.state = erssa_pkg::ST_READ;
                end
            end else if (r_reg.ap_addr == erssa_pkg::OFS_WORK) begin
                r_next.work = hwdata[7:0];
            end else if (r_reg.ap_addr == erssa_pkg::OFS_FLAGS) begin
                r_next.flags = hwdata[erssa_pkg::FLAGS_W-1:0];
            end else if (r_reg.ap_addr == erssa_pkg::OFS_MADDR) begin
                r_next.maddr = hwdata[erssa_pkg::MEM_AW-1:0];
            end else if (r_reg.ap_addr == erssa_pkg::OFS_MDATA) begin
                r_next.mem[r_reg.maddr] = hwdata[7:0];
            end
        end

        case (r_reg.state)
            erssa_pkg::ST_IDLE: begin
            end
            erssa_pkg::ST_READ: begin
                r_next.operand = r_reg.mem[r_reg.addr]; // RULE_21
                r_next.state = erssa_pkg::ST_EXEC;
            end
            erssa_pkg::ST_EXEC: begin
                case (r_reg.op)
                    erssa_pkg::OP_ROTATE_LEFT_MEM,
                    erssa_pkg::OP_ROTATE_LEFT_TO_WORK: begin
                        res = {r_reg.operand[6:0], r_reg.operand[7]}; // RULE_01
                    end
                    erssa_pkg::OP_ROTATE_LEFT_THRU_CARRY_MEM,
                    erssa_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WORK: begin
                        res = {r_reg.operand[6:0], carry_now}; // RULE_03
                        r_next.flags[erssa_pkg::FLG_C] = r_reg.operand[7]; // RULE_03
                    end
                    erssa_pkg::OP_ROTATE_RIGHT_MEM,
                    erssa_pkg::OP_ROTATE_RIGHT_TO_WORK: begin
                        res = {r_reg.operand[0], r_reg.operand[7:1]}; // RULE_04
                    end
                    erssa_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM,
                    erssa_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK: begin
                        res = {carry_now, r_reg.operand[7:1]}; // RULE_05
                        r_next.flags[erssa_pkg::FLG_C] = r_reg.operand[0]; // RULE_05
                    end
                    erssa_pkg::OP_SUBTRACT_BORROW_TO_WORK,
                    erssa_pkg::OP_SUBTRACT_BORROW_TO_MEM,
                    erssa_pkg::OP_SUBTRACT_TO_WORK,
                    erssa_pkg::OP_SUBTRACT_TO_MEM: begin
                        // borrow forms take the inverted carry, plain ones take none
                        borrow_in = !r_reg.op[1] && !carry_now; // RULE_06 RULE_08
                        diff = sub9({1'b0, r_reg.work}, {1'b0, r_reg.operand}, borrow_in);
                        nib = sub9({5'h00, r_reg.work[3:0]}, {5'h00, r_reg.operand[3:0]},
                                   borrow_in);
                        res = diff[7:0];
                        r_next.flags[erssa_pkg::FLG_C] = !diff[8]; // RULE_09
                        r_next.flags[erssa_pkg::FLG_AC] = !nib[4]; // RULE_10
                        r_next.flags[erssa_pkg::FLG_Z] = (diff[7:0] == erssa_pkg::BYTE_ZERO);
                        r_next.flags[erssa_pkg::FLG_OV] = (r_reg.work[7] ^ r_reg.operand[7])
                                                          && (diff[7] ^ r_reg.work[7]);
                        r_next.flags[erssa_pkg::FLG_SC] = r_next.flags[erssa_pkg::FLG_OV]
                                                          ^ diff[7]; // RULE_10
                        // chained zero keeps a multi-byte zero across borrow steps
                        r_next.flags[erssa_pkg::FLG_CZ] = r_next.flags[erssa_pkg::FLG_Z]
                            && (r_reg.op[1] || r_reg.flags[erssa_pkg::FLG_CZ]); // RULE_10
                    end
                    erssa_pkg::OP_DECREMENT_SKIP_ZERO_MEM,
                    erssa_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK: begin
                        res = r_reg.operand - 8'h01; // RULE_12 RULE_13
                        skip = (res == erssa_pkg::BYTE_ZERO);
                    end
                    erssa_pkg::OP_INCREMENT_SKIP_ZERO_MEM,
                    erssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK: begin
                        res = r_reg.operand + 8'h01; // RULE_14 RULE_15
                        skip = (res == erssa_pkg::BYTE_ZERO);
                    end
                    erssa_pkg::OP_SET_ALL_ONES: begin
                        res = erssa_pkg::BYTE_ONES; // RULE_16
                    end
                    erssa_pkg::OP_SET_BIT: begin
                        res[r_reg.bit_sel] = 1'b1; // RULE_17
                    end
                    erssa_pkg::OP_SKIP_IF_BIT_SET: begin
                        skip = r_reg.operand[r_reg.bit_sel]; // RULE_18
                    end
                    erssa_pkg::OP_SKIP_IF_NONZERO: begin
                        skip = (r_reg.operand != erssa_pkg::BYTE_ZERO); // RULE_19
                    end
                    erssa_pkg::OP_SKIP_IF_ZERO_BYTE: begin
                        skip = (r_reg.operand == erssa_pkg::BYTE_ZERO);
                    end
                    erssa_pkg::OP_NIBBLE_EXCHANGE_MEM,
                    erssa_pkg::OP_NIBBLE_EXCHANGE_TO_WORK: begin
                        res = {r_reg.operand[3:0], r_reg.operand[7:4]}; // RULE_20
                    end
                    default: begin
                    end
                endcase

                case (r_reg.op)
                    erssa_pkg::OP_ROTATE_LEFT_TO_WORK,
                    erssa_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WORK,
                    erssa_pkg::OP_ROTATE_RIGHT_TO_WORK,
                    erssa_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK,
                    erssa_pkg::OP_SUBTRACT_BORROW_TO_WORK,
                    erssa_pkg::OP_SUBTRACT_TO_WORK,
                    erssa_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK,
                    erssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK,
                    erssa_pkg::OP_NIBBLE_EXCHANGE_TO_WORK: begin
                        wr_work = 1'b1; // RULE_02
                    end
                    erssa_pkg::OP_SKIP_IF_BIT_SET: begin
                    end
                    default: begin
                        // nonzero and zero skips rewrite the byte unchanged
                        wr_mem = (r_reg.op <= erssa_pkg::OP_SKIP_IF_ZERO_BYTE); // RULE_07 RULE_19
                    end
                endcase

                if (wr_work) begin
                    r_next.work = res; // RULE_02 RULE_13 RULE_15
                end
                if (wr_mem) begin
                    r_next.mem[r_reg.addr] = res; // RULE_07 RULE_12 RULE_14 RULE_21
                end
                r_next.skip_last = skip;
                r_next.done = !skip;
                r_next.state = skip ? erssa_pkg::ST_DUMMY : erssa_pkg::ST_IDLE; // RULE_11
            end
            erssa_pkg::ST_DUMMY: begin
                // the discarded fetch: nothing is written in this cycle
                r_next.done = 1'b1; // RULE_11
                r_next.state = erssa_pkg::ST_IDLE;
            end
            default: begin
                r_next.state = erssa_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // all reset values, including work and flags, are zero
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic is_exec;
    assign is_exec = (r_reg.state == erssa_pkg::ST_EXEC);

    a_rotl_mem: assert property ( // RULE_01
        is_exec && r_reg.op == erssa_pkg::OP_ROTATE_LEFT_MEM |=>
        r_reg.mem[r_reg.addr] == {r_reg.operand[6:0], r_reg.operand[7]}
        && r_reg.flags == $past(r_reg.flags))
        else $error("rotate left into memory wrong");

    a_work_mem_kept: assert property ( // RULE_02
        is_exec && r_reg.op == erssa_pkg::OP_NIBBLE_EXCHANGE_TO_WORK |=>
        r_reg.mem[r_reg.addr] == r_reg.operand
        && r_reg.work == {r_reg.operand[3:0], r_reg.operand[7:4]})
        else $error("nibble exchange to work wrong or memory touched");

    a_rlc_ring: assert property ( // RULE_03
        is_exec && r_reg.op == erssa_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WORK |=>
        r_reg.work == {r_reg.operand[6:0], $past(carry_now)}
        && carry_now == r_reg.operand[7])
        else $error("rotate left through carry wrong");

    a_rrc_ring: assert property ( // RULE_05
        is_exec && r_reg.op == erssa_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM |=>
        r_reg.mem[r_reg.addr] == {$past(carry_now), r_reg.operand[7:1]}
        && carry_now == r_reg.operand[0])
        else $error("rotate right through carry wrong");

    a_sub_carry: assert property ( // RULE_09
        is_exec && r_reg.op == erssa_pkg::OP_SUBTRACT_TO_WORK |=>
        carry_now == ($past(r_reg.work) >= r_reg.operand)
        && r_reg.work == $past(r_reg.work) - r_reg.operand)
        else $error("subtract carry or result wrong");

    sequence s_skip_tail;
        skip_cycle ##1 (r_reg.state == erssa_pkg::ST_IDLE && op_done);
    endsequence

    a_skip_three: assert property ( // RULE_11
        r_reg.state == erssa_pkg::ST_READ ##1 (is_exec && skip) |=> s_skip_tail)
        else $error("skip did not take one dummy cycle");

    a_dec_skip: assert property ( // RULE_12
        is_exec && r_reg.op == erssa_pkg::OP_DECREMENT_SKIP_ZERO_MEM
        && r_reg.operand == 8'h01 |=> skip_cycle && r_reg.mem[r_reg.addr] == 8'h00)
        else $error("decrement skip did not skip on zero");

    a_set_ones: assert property ( // RULE_16
        is_exec && r_reg.op == erssa_pkg::OP_SET_ALL_ONES |=>
        r_reg.mem[r_reg.addr] == 8'hFF && $stable(r_reg.flags))
        else $error("set all ones wrong");

    a_rotr_work: assert property ( // RULE_04
        is_exec && r_reg.op == erssa_pkg::OP_ROTATE_RIGHT_TO_WORK |=>
        r_reg.work == {r_reg.operand[0], r_reg.operand[7:1]} && $stable(r_reg.flags))
        else $error("rotate right to work wrong");

    a_sbc_mem: assert property ( // RULE_06 RULE_07
        is_exec && r_reg.op == erssa_pkg::OP_SUBTRACT_BORROW_TO_MEM |=>
        r_reg.mem[r_reg.addr] == $past(r_reg.work) - r_reg.operand - !$past(carry_now)
        && $stable(r_reg.work))
        else $error("subtract with borrow into memory wrong");

    a_inc_work: assert property ( // RULE_15
        is_exec && r_reg.op == erssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK |=>
        r_reg.work == r_reg.operand + 8'h01 && r_reg.mem[r_reg.addr] == r_reg.operand
        && skip_cycle == (r_reg.work == 8'h00))
        else $error("increment skip to work wrong");

    a_set_bit: assert property ( // RULE_17
        is_exec && r_reg.op == erssa_pkg::OP_SET_BIT |=>
        r_reg.mem[r_reg.addr] == (r_reg.operand | (8'h01 << r_reg.bit_sel))
        && $stable(r_reg.flags))
        else $error("set bit wrong");

    a_bit_skip: assert property ( // RULE_18
        is_exec && r_reg.op == erssa_pkg::OP_SKIP_IF_BIT_SET |=>
        skip_cycle == r_reg.operand[r_reg.bit_sel] && r_reg.mem[r_reg.addr] == r_reg.operand)
        else $error("bit skip wrong");

    a_nz_skip: assert property ( // RULE_19
        is_exec && r_reg.op == erssa_pkg::OP_SKIP_IF_NONZERO |=>
        skip_cycle == (r_reg.operand != 8'h00) && r_reg.mem[r_reg.addr] == r_reg.operand
        && $stable(r_reg.flags))
        else $error("nonzero skip wrong");

    a_swap_mem: assert property ( // RULE_20
        is_exec && r_reg.op == erssa_pkg::OP_NIBBLE_EXCHANGE_MEM |=>
        r_reg.mem[r_reg.addr] == {r_reg.operand[3:0], r_reg.operand[7:4]}
        && $stable(r_reg.flags))
        else $error("nibble exchange into memory wrong");

    a_op_cycles: assert property ( // RULE_21
        r_reg.state == erssa_pkg::ST_READ |=> is_exec ##1 (skip_cycle || !op_busy))
        else $error("operation did not finish within its cycles");

    c_skip_taken: cover property (is_exec && skip ##1 skip_cycle);
    c_sub_borrow: cover property (is_exec && r_reg.op == erssa_pkg::OP_SUBTRACT_BORROW_TO_MEM);
    c_set_bit: cover property (is_exec && r_reg.op == erssa_pkg::OP_SET_BIT);
    c_no_skip: cover property (is_exec && !skip && r_reg.op == erssa_pkg::OP_SKIP_IF_NONZERO);
endmodule // erssa_alu

// file: rtl/erssa_pkg.sv
package erssa_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WORK = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_MADDR = 8'h10;
    localparam logic [7:0] OFS_MDATA = 8'h14;
    // command word layout
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 5;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_BIT_W = 3;
    localparam int CMD_ADDR_LSB = 16;
    // data memory: four sections of sixteen bytes
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 64;
    // flag register layout
    localparam int FLAGS_W = 6;
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SC = 4;
    localparam int FLG_CZ = 5;
    // status register layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_SKIP = 1;
    // reset values and byte constants
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10,
        ST_DUMMY = 2'b11
    } erssa_state_t;

    typedef enum logic [4:0] {
        OP_ROTATE_LEFT_MEM = 5'h00,
        OP_ROTATE_LEFT_TO_WORK = 5'h01,
        OP_ROTATE_LEFT_THRU_CARRY_MEM = 5'h02,
        OP_ROTATE_LEFT_THRU_CARRY_TO_WORK = 5'h03,
        OP_ROTATE_RIGHT_MEM = 5'h04,
        OP_ROTATE_RIGHT_TO_WORK = 5'h05,
        OP_ROTATE_RIGHT_THRU_CARRY_MEM = 5'h06,
        OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK = 5'h07,
        OP_SUBTRACT_BORROW_TO_WORK = 5'h08,
        OP_SUBTRACT_BORROW_TO_MEM = 5'h09,
        OP_SUBTRACT_TO_WORK = 5'h0A,
        OP_SUBTRACT_TO_MEM = 5'h0B,
        OP_DECREMENT_SKIP_ZERO_MEM = 5'h0C,
        OP_DECREMENT_SKIP_ZERO_TO_WORK = 5'h0D,
        OP_INCREMENT_SKIP_ZERO_MEM = 5'h0E,
        OP_INCREMENT_SKIP_ZERO_TO_WORK = 5'h0F,
        OP_SET_ALL_ONES = 5'h10,
        OP_SET_BIT = 5'h11,
        OP_SKIP_IF_BIT_SET = 5'h12,
        OP_SKIP_IF_NONZERO = 5'h13,
        OP_NIBBLE_EXCHANGE_MEM = 5'h14,
        OP_NIBBLE_EXCHANGE_TO_WORK = 5'h15,
        OP_SKIP_IF_ZERO_BYTE = 5'h16
    } erssa_op_t;
endpackage

// file: testbench/erssa_host.sv
`timescale 1ns/1ps
module erssa_host (
    input wire logic hclk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = erssa_pkg::HSIZE_WORD;
        hwdata = 32'h0;
    end

    // single word transfer; each call starts on a fresh edge, so calls never overlap
    task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= erssa_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask
endmodule // erssa_host

// file: testbench/tb_extended_rotate_sub_skip_alu.sv
`timescale 1ns/1ps
module tb_extended_rotate_sub_skip_alu;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic op_done;
    logic skip_cycle;
    logic hresp;
    logic op_busy;
    int err_total;
    int n_compared;
    int seed;

    erssa_alu i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .op_busy(op_busy), .skip_cycle(skip_cycle), .op_done(op_done));
    erssa_host i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic complete_run;
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(ofs, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [31:0] q);
        i_host.xfer(ofs, 1'b0, 32'h0, q);
        chk("response", {31'h0, erssa_pkg::HRESP_OKAY}, {31'h0, hresp});
    endtask

    function automatic void model(input logic [4:0] op, input logic [2:0] b,
        input logic [7:0] m, input logic [7:0] w, input logic [5:0] f,
        output logic [7:0] nm, output logic [7:0] nw, output logic [5:0] nf, output logic sk);
        logic [8:0] d;
        logic [4:0] h;
        logic bin;
        logic [7:0] r;
        nm = m;
        nw = w;
        nf = f;
        sk = 1'b0;
        r = m;
        bin = (op < 5'h0A) ? ~f[0] : 1'b0;
        d = {1'b0, w} - {1'b0, m} - {8'h0, bin};
        h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
        case (op)
            5'h00, 5'h01: r = {m[6:0], m[7]};
            5'h02, 5'h03: begin
                r = {m[6:0], f[0]};
                nf[0] = m[7];
            end
            5'h04, 5'h05: r = {m[0], m[7:1]};
            5'h06, 5'h07: begin
                r = {f[0], m[7:1]};
                nf[0] = m[0];
            end
            5'h08, 5'h09, 5'h0A, 5'h0B: begin
                r = d[7:0];
                nf[0] = ~d[8];
                nf[1] = ~h[4];
                nf[2] = (r == 8'h00);
                nf[3] = (w[7] != m[7]) && (r[7] != w[7]);
                nf[4] = nf[3] ^ r[7];
                nf[5] = (op < 5'h0A) ? (nf[2] & f[5]) : nf[2];
            end
            5'h0C, 5'h0D: begin
                r = m - 8'h01;
                sk = (r == 8'h00);
            end
            5'h0E, 5'h0F: begin
                r = m + 8'h01;
                sk = (r == 8'h00);
            end
            5'h10: r = erssa_pkg::BYTE_ONES;
            5'h11: r = m | (8'h01 << b);
            5'h12: sk = m[b];
            5'h13: sk = (m != 8'h00);
            5'h14, 5'h15: r = {m[3:0], m[7:4]};
            5'h16: sk = (m == 8'h00);
            default: ;
        endcase
        if (op inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h08, 5'h0A, 5'h0D, 5'h0F, 5'h15})
            nw = r;
        else if (op < 5'h17) nm = r;
    endfunction

    task automatic run_op(input logic [4:0] op, input logic [2:0] b, input logic [5:0] a,
        input logic [7:0] m, input logic [7:0] w, input logic [5:0] f);
        logic [7:0] em;
        logic [7:0] ew;
        logic [5:0] ef;
        logic sk;
        logic seen;
        int n;
        int nb;
        logic [31:0] q;
        model(op, b, m, w, f, em, ew, ef, sk);
        wr(erssa_pkg::OFS_MADDR, {26'h0, a});
        wr(erssa_pkg::OFS_MDATA, {24'h0, m});
        wr(erssa_pkg::OFS_WORK, {24'h0, w});
        wr(erssa_pkg::OFS_FLAGS, {26'h0, f});
        wr(erssa_pkg::OFS_CMD, {10'h0, a, 5'h0, b, 3'h0, op});
        n = 0;
        nb = 0;
        seen = 1'b0;
        while (op_done !== 1'b1 && n < 10) begin
            @(negedge hclk);
            n++;
            if (skip_cycle === 1'b1) seen = 1'b1;
            if (op_busy === 1'b1) nb++;
        end
        chk("op cycles", {31'h0, sk} + 32'h3, n);
        chk("skip pulse", {31'h0, sk}, {31'h0, seen});
        chk("busy cycles", {31'h0, sk} + 32'h2, nb);
        rd(erssa_pkg::OFS_STAT, q);
        chk("status", {30'h0, sk, 1'b0}, q);
        rd(erssa_pkg::OFS_WORK, q);
        chk("work", {24'h0, ew}, q);
        rd(erssa_pkg::OFS_FLAGS, q);
        chk("flags", {26'h0, ef}, q);
        rd(erssa_pkg::OFS_MDATA, q);
        chk("memory", {24'h0, em}, q);
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        complete_run;
    end

    initial begin
        logic [31:0] q;
        logic [31:0] rv;
        seed = 32'hBB2D037B;
        err_total = 0;
        n_compared = 0;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wr(8'h18, 32'hFFFFFFFF);
        // offsets 0x00..0x14 read reset zero, 0x18 is unmapped
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), q);
            chk("reset or unmapped", 32'h0, q);
        end
        // boundary values: wrap to zero, borrow, overflow, last section
        run_op(5'h0C, 3'h0, 6'h3F, 8'h01, 8'h55, 6'h00);
        run_op(5'h0D, 3'h0, 6'h30, 8'h01, 8'h55, 6'h3F);
        run_op(5'h0E, 3'h0, 6'h20, 8'hFF, 8'h00, 6'h00);
        run_op(5'h0F, 3'h0, 6'h10, 8'hFF, 8'h12, 6'h15);
        run_op(5'h0A, 3'h0, 6'h05, 8'h42, 8'h42, 6'h00);
        run_op(5'h0B, 3'h0, 6'h06, 8'h43, 8'h42, 6'h3F);
        run_op(5'h08, 3'h0, 6'h07, 8'h00, 8'h00, 6'h20);
        run_op(5'h09, 3'h0, 6'h08, 8'h01, 8'h80, 6'h21);
        run_op(5'h12, 3'h7, 6'h09, 8'h80, 8'h00, 6'h00);
        run_op(5'h13, 3'h0, 6'h0A, 8'h00, 8'h00, 6'h00);
        run_op(5'h1F, 3'h0, 6'h0B, 8'h5A, 8'hA5, 6'h2A);
        for (int i = 0; i < 23; i++) begin
            rv = $random(seed);
            run_op(5'(i), rv[2:0], rv[13:8], rv[23:16], rv[31:24], rv[7:2]);
        end
        for (int i = 0; i < 150; i++) begin
            rv = $random(seed);
            q = $random(seed);
            run_op(5'(q % 24), rv[2:0], rv[13:8], rv[23:16], rv[31:24], q[29:24]);
        end
        complete_run;
    end
endmodule // tb_extended_rotate_sub_skip_alu
